// ### chb_consts.svh
// register offsets, field positions and numeric constants for the channel b config block
`ifndef CHB_CONSTS_SVH
`define CHB_CONSTS_SVH
`define REG_CUST_LO    8'h51
`define REG_CUST_HI    8'h52
`define REG_CORR_EN    8'h66
`define REG_GAIN_TC    8'h68
`define REG_COEFS      8'h69
`define REG_TRIM       8'h6a
`define REG_SHP_EN     8'h6c
`define REG_PATTERN    8'h75
`define REG_PEDESTAL   8'h76
`define CORR_EN_BIT    6
`define SHP_EN_BIT     0
`define TC_BASE_SHIFT  6'h12
`define TC_MAX_CODE    4'ha
`define COARSE_MAX     4'hc
`define COARSE_SHIFT   12
`define TRIM_SHIFT     13
`define TRIM_UNITY     15'h2000
`define MID_CODE       13'h0400
`define CODE_MAX       11'h7ff
`define TOGGLE_A       11'h2aa
`define TOGGLE_B       11'h555
`define RAMP_LAST_PH   3'h7
`endif

// ### chb_pkg.sv
// types shared by the channel b config block and its pattern generator
`default_nettype none
package chb_pkg;
  typedef enum logic [2:0] {
    PAT_NORMAL = 3'h0,
    PAT_ZEROS  = 3'h1,
    PAT_ONES   = 3'h2,
    PAT_TOGGLE = 3'h3,
    PAT_RAMP   = 3'h4,
    PAT_CUSTOM = 3'h5,
    PAT_UNUSED6 = 3'h6,
    PAT_UNUSED7 = 3'h7
  } pattern_t;

  typedef struct packed {
    logic [3:0] coarse;
    logic [3:0] tc;
    logic [3:0] coef1;
    logic [3:0] coef2;
    logic [6:0] trim;
    logic       shp_en;
    pattern_t   pat;
    logic [5:0] ped;
    logic       corr_en;
  } chan_cfg_t;

  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_wr_t;

  typedef struct packed {
    logic       en;
    logic [3:0] coef1;
    logic [3:0] coef2;
  } shaping_t;
endpackage
`default_nettype wire

// ### chb_pattern_gen.sv
// test-pattern substitution on the channel b output word
`include "chb_consts.svh"
`default_nettype none
module chb_pattern_gen (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire chb_pkg::pattern_t sel,
  input  wire logic [10:0]       data_in,
  input  wire logic [10:0]       custom,
  output var  logic [10:0]       data_out
);
  import chb_pkg::*;

  typedef struct packed {
    logic [10:0] ramp;
    logic [2:0]  phase;
    logic        tog;
    logic [10:0] out;
  } pg_state_t;

  pg_state_t st_reg;
  pg_state_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.tog = ~st_reg.tog;
    st_next.phase = st_reg.phase + 3'h1;
    if (st_reg.phase == `RAMP_LAST_PH) begin
      st_next.ramp = st_reg.ramp + 11'h001; // R12
    end
    case (sel)
      PAT_NORMAL: st_next.out = data_in;
      PAT_ZEROS:  st_next.out = 11'h000; // R10
      PAT_ONES:   st_next.out = `CODE_MAX; // R10
      PAT_TOGGLE: st_next.out = st_reg.tog ? `TOGGLE_B : `TOGGLE_A; // R11
      PAT_RAMP:   st_next.out = st_reg.ramp; // R12
      PAT_CUSTOM: st_next.out = custom; // R13
      default:    st_next.out = data_in;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign data_out = st_reg.out;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence ramp_edge_s;
    sel == PAT_RAMP && st_reg.phase == `RAMP_LAST_PH;
  endsequence
  sequence ramp_hold_s;
    st_reg.phase != `RAMP_LAST_PH;
  endsequence

  zeros_ones_a: assert property (sel == PAT_ZEROS || sel == PAT_ONES |=> data_out == {11{$past(sel) == PAT_ONES}}) // R10
    else $error("zero pattern not all low");
  toggle_alt_a: assert property ((sel == PAT_TOGGLE)[*3] |-> data_out != $past(data_out) && // R11
    (data_out == `TOGGLE_A || data_out == `TOGGLE_B))
    else $error("toggle pattern not alternating");
  ramp_step_a: assert property (ramp_edge_s ##1 sel == PAT_RAMP |=> data_out == $past(data_out) + 11'h001) // R12
    else $error("ramp did not step on eighth cycle");
  ramp_hold_a: assert property (ramp_hold_s |=> st_reg.ramp == $past(st_reg.ramp)) // R12
    else $error("ramp moved between steps");
  custom_word_a: assert property (sel == PAT_CUSTOM |=> data_out == $past(custom)) // R13
    else $error("custom word not driven");
endmodule // chb_pattern_gen
`default_nettype wire

// ### chb_digital_cfg.sv
// channel b digital config registers, offset loop, gain and output select
// Summary of operation
// R01: D6 of offset-enable register turns correction on
// R02: channel b settings apply only when independent; the code also uses the channel b custom word in common mode
// R03: upper gain nibble: coarse gain, 0.5 dB steps
// R04: lower nibble: loop constant 256k doubling upward
// R05: one byte holds both shaping coefficients
// R06: fine trim is additive, 128 steps
// R07: trim factor is one plus code over 8192
// R08: total gain is coarse plus fine trim
// R09: bit D0 of 0x6c enables noise shaping
// R10: selector 000 normal, 001 zeros, 010 ones
// R11: selector 011 alternates two toggle words
// R12: selector 100 ramps every eighth cycle
// R13: selector 101 outputs custom word
// R14: enabled loop converges to mid-code plus pedestal
// R15: pedestal is six-bit two's complement
// R16: common control uses channel a settings
// R17: custom word: five low, six high bits
// R18: reset clears all channel b fields
`include "chb_consts.svh"
`default_nettype none
module chb_digital_cfg #(
  parameter int DATA_W = 11,
  parameter int ACC_W  = 44
) (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire chb_pkg::reg_wr_t  reg_wr,
  input  wire logic [7:0]        rd_addr,
  output var  logic [7:0]        rd_data,
  input  wire logic              common_ctrl,
  input  wire chb_pkg::chan_cfg_t cha_cfg,
  input  wire logic [DATA_W-1:0] adc_in,
  output var  logic [DATA_W-1:0] sample_out,
  output var  chb_pkg::shaping_t shaping
);
  import chb_pkg::*;

  typedef struct packed {
    chan_cfg_t              cfg;
    logic [4:0]             cust_lo;
    logic [5:0]             cust_hi;
    logic signed [ACC_W-1:0] acc;
    logic [DATA_W-1:0]      proc;
    logic [7:0]             rd;
    shaping_t               shp;
  } state_t;

  state_t    st_reg;
  state_t    st_next;
  chan_cfg_t eff;

  // coarse gain multiplier in q.12, 10^(code/40)
  function automatic logic [13:0] coarse_mult(input logic [3:0] code);
    logic [3:0] c;
    c = (code > `COARSE_MAX) ? `COARSE_MAX : code;
    case (c)
      4'h0:    coarse_mult = 14'h1000;
      4'h1:    coarse_mult = 14'h10f3;
      4'h2:    coarse_mult = 14'h11f4;
      4'h3:    coarse_mult = 14'h1304;
      4'h4:    coarse_mult = 14'h1425;
      4'h5:    coarse_mult = 14'h1557;
      4'h6:    coarse_mult = 14'h169a;
      4'h7:    coarse_mult = 14'h17f1;
      4'h8:    coarse_mult = 14'h195c;
      4'h9:    coarse_mult = 14'h1add;
      4'ha:    coarse_mult = 14'h1c74;
      4'hb:    coarse_mult = 14'h1e24;
      4'hc:    coarse_mult = 14'h1fed;
      default: coarse_mult = 14'h1000;
    endcase
  endfunction

  // loop time constant as a shift, 2^18 cycles at code 0
  function automatic logic [5:0] tc_shift(input logic [3:0] code);
    logic [3:0] c;
    c = (code > `TC_MAX_CODE) ? `TC_MAX_CODE : code;
    tc_shift = `TC_BASE_SHIFT + {2'b00, c};
  endfunction

  // register image for readback
  function automatic logic [7:0] reg_image(input state_t s, input logic [7:0] a);
    reg_image = 8'h00;
    case (a)
      `REG_CUST_LO:  reg_image = {s.cust_lo, 3'b000};
      `REG_CUST_HI:  reg_image = {2'b00, s.cust_hi};
      `REG_CORR_EN:  reg_image = {1'b0, s.cfg.corr_en, 6'h00};
      `REG_GAIN_TC:  reg_image = {s.cfg.coarse, s.cfg.tc};
      `REG_COEFS:    reg_image = {s.cfg.coef1, s.cfg.coef2};
      `REG_TRIM:     reg_image = {1'b0, s.cfg.trim};
      `REG_SHP_EN:   reg_image = {7'h00, s.cfg.shp_en};
      `REG_PATTERN:  reg_image = {5'h00, s.cfg.pat};
      `REG_PEDESTAL: reg_image = {2'b00, s.cfg.ped};
      default:       reg_image = 8'h00;
    endcase
  endfunction

  // effective settings: channel a in common mode
  always_comb begin
    eff = common_ctrl ? cha_cfg : st_reg.cfg; // R02 R16
  end

  logic signed [ACC_W-1:0] est;
  logic signed [12:0]      corr;
  logic signed [12:0]      target;
  logic signed [12:0]      err;
  logic signed [12:0]      cen;
  logic signed [27:0]      p1;
  logic signed [15:0]      g1;
  logic signed [31:0]      p2;
  logic signed [15:0]      g2;
  logic signed [15:0]      outv;
  logic [DATA_W-1:0]       custom_word;
  logic [DATA_W-1:0]       pat_out;

  always_comb begin
    est    = st_reg.acc >>> tc_shift(eff.tc); // R04
    target = `MID_CODE + {{7{eff.ped[5]}}, eff.ped}; // R14 R15
    if (eff.corr_en) begin
      corr = $signed({2'b00, adc_in}) - est[12:0]; // R01 R14
    end else begin
      corr = $signed({2'b00, adc_in});
    end
    err  = corr - target;
    cen  = corr - `MID_CODE;
    p1   = cen * $signed({1'b0, coarse_mult(eff.coarse)}); // R03
    g1   = 16'(p1 >>> `COARSE_SHIFT);
    p2   = g1 * $signed({1'b0, `TRIM_UNITY + {8'h00, eff.trim}}); // R06 R07 R08
    g2   = 16'(p2 >>> `TRIM_SHIFT);
    outv = g2 + 16'(`MID_CODE);
  end

  always_comb begin
    st_next = st_reg;
    if (reg_wr.we) begin
      case (reg_wr.addr)
        `REG_CUST_LO:  st_next.cust_lo = reg_wr.data[7:3]; // R17
        `REG_CUST_HI:  st_next.cust_hi = reg_wr.data[5:0]; // R17
        `REG_CORR_EN:  st_next.cfg.corr_en = reg_wr.data[`CORR_EN_BIT]; // R01
        `REG_GAIN_TC: begin
          st_next.cfg.coarse = reg_wr.data[7:4]; // R03
          st_next.cfg.tc = reg_wr.data[3:0]; // R04
        end
        `REG_COEFS: begin
          st_next.cfg.coef1 = reg_wr.data[7:4]; // R05
          st_next.cfg.coef2 = reg_wr.data[3:0]; // R05
        end
        `REG_TRIM:     st_next.cfg.trim = reg_wr.data[6:0]; // R06
        `REG_SHP_EN:   st_next.cfg.shp_en = reg_wr.data[`SHP_EN_BIT]; // R09
        `REG_PATTERN:  st_next.cfg.pat = pattern_t'(reg_wr.data[2:0]); // R10
        `REG_PEDESTAL: st_next.cfg.ped = reg_wr.data[5:0]; // R15
        default: ;
      endcase
    end
    // loop integrates the residual; cleared while off
    if (eff.corr_en) begin
      st_next.acc = st_reg.acc + ACC_W'(err); // R14
    end else begin
      st_next.acc = '0;
    end
    if (outv < 16'sh0000) begin
      st_next.proc = '0;
    end else if (outv > $signed({5'h00, `CODE_MAX})) begin
      st_next.proc = `CODE_MAX;
    end else begin
      st_next.proc = outv[DATA_W-1:0];
    end
    st_next.rd = reg_image(st_reg, rd_addr);
    st_next.shp.en = eff.shp_en; // R09
    st_next.shp.coef1 = eff.coef1; // R05
    st_next.shp.coef2 = eff.coef2; // R05
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_reg <= '0; // R18
    end else begin
      st_reg <= st_next;
    end
  end

  assign custom_word = {st_reg.cust_hi, st_reg.cust_lo}; // R17

  chb_pattern_gen u_pattern (
    .mclk     (mclk),
    .rst      (rst),
    .sel      (eff.pat),
    .data_in  (st_reg.proc),
    .custom   (custom_word),
    .data_out (pat_out)
  );

  assign sample_out = pat_out;
  assign rd_data    = st_reg.rd;
  assign shaping    = st_reg.shp;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence wr_at_s(logic [7:0] a);
    reg_wr.we && reg_wr.addr == a;
  endsequence

  // unity gain, no correction, live data
  sequence idle_path_s;
    !eff.corr_en && eff.coarse == 4'h0 && eff.trim == 7'h00 && eff.pat == PAT_NORMAL;
  endsequence

  sequence loop_start_s;
    !eff.corr_en ##1 eff.corr_en;
  endsequence

  sequence own_ctrl_s(pattern_t p);
    !common_ctrl && st_reg.cfg.pat == p;
  endsequence

  corr_enable_a: assert property (wr_at_s(`REG_CORR_EN) |=> // R01
    st_reg.cfg.corr_en == $past(reg_wr.data[`CORR_EN_BIT]))
    else $error("offset enable bit not stored");
  coarse_store_a: assert property (wr_at_s(`REG_GAIN_TC) |=> st_reg.cfg.coarse == $past(reg_wr.data[7:4])) // R03
    else $error("coarse gain not stored");
  coef_split_a: assert property (wr_at_s(`REG_COEFS) |=> st_reg.cfg.coef2 == $past(reg_wr.data[3:0]) // R05
    && st_reg.cfg.coef1 == $past(reg_wr.data[7:4]))
    else $error("coefficient nibbles swapped");
  shaping_en_a: assert property (wr_at_s(`REG_SHP_EN) ##1 !common_ctrl |=> shaping.en == $past(reg_wr.data[0], 2)) // R09
    else $error("shaping enable not applied");
  common_sel_a: assert property (common_ctrl |=> // R16
    shaping == {$past(cha_cfg.shp_en), $past(cha_cfg.coef1), $past(cha_cfg.coef2)})
    else $error("common control not using channel a");
  indep_sel_a: assert property (!common_ctrl |=> // R02
    shaping == {$past(st_reg.cfg.shp_en), $past(st_reg.cfg.coef1), $past(st_reg.cfg.coef2)})
    else $error("independent control not using channel b");
  ped_read_a: assert property (rd_addr == `REG_PEDESTAL |=> rd_data == {2'b00, $past(st_reg.cfg.ped)}) // R15
    else $error("pedestal readback wrong");
  loop_off_a: assert property (!eff.corr_en |=> st_reg.acc == '0) // R14
    else $error("loop accumulator not cleared while off");
  reset_clear_a: assert property (@(posedge mclk) disable iff (1'b0) rst |=> st_reg.cfg == '0) // R18
    else $error("config not cleared by reset");

  reset_out_a: assert property ( // R18
    @(posedge mclk) disable iff (1'b0) rst |=>
    sample_out == '0 && rd_data == 8'h00 && shaping == '0)
    else $error("outputs not cleared by reset");

  cust_lo_store_a: assert property ( // R17
    wr_at_s(`REG_CUST_LO) |=>
    st_reg.cust_lo == $past(reg_wr.data[7:3]))
    else $error("custom low bits not stored");

  cust_hi_store_a: assert property ( // R17
    wr_at_s(`REG_CUST_HI) |=>
    st_reg.cust_hi == $past(reg_wr.data[5:0]))
    else $error("custom high bits not stored");

  tc_store_a: assert property ( // R04
    wr_at_s(`REG_GAIN_TC) |=>
    st_reg.cfg.tc == $past(reg_wr.data[3:0]))
    else $error("loop time constant not stored");

  trim_store_a: assert property ( // R06
    wr_at_s(`REG_TRIM) |=>
    st_reg.cfg.trim == $past(reg_wr.data[6:0]))
    else $error("fine trim not stored");

  shp_store_a: assert property ( // R09
    wr_at_s(`REG_SHP_EN) |=>
    st_reg.cfg.shp_en == $past(reg_wr.data[`SHP_EN_BIT]))
    else $error("shaping enable bit not stored");

  pat_store_a: assert property ( // R10
    wr_at_s(`REG_PATTERN) |=>
    st_reg.cfg.pat == $past(reg_wr.data[2:0]))
    else $error("pattern selector not stored");

  ped_store_a: assert property ( // R15
    wr_at_s(`REG_PEDESTAL) |=>
    st_reg.cfg.ped == $past(reg_wr.data[5:0]))
    else $error("pedestal not stored");

  gain_read_a: assert property ( // R03 R04
    rd_addr == `REG_GAIN_TC |=>
    rd_data == {$past(st_reg.cfg.coarse), $past(st_reg.cfg.tc)})
    else $error("gain register readback wrong");

  corr_read_a: assert property ( // R01
    rd_addr == `REG_CORR_EN |=>
    rd_data == {1'b0, $past(st_reg.cfg.corr_en), 6'h00})
    else $error("offset enable readback wrong");

  trim_read_a: assert property ( // R06
    rd_addr == `REG_TRIM |=>
    rd_data == {1'b0, $past(st_reg.cfg.trim)})
    else $error("fine trim readback wrong");

  coef_read_a: assert property ( // R05
    rd_addr == `REG_COEFS |=>
    rd_data == {$past(st_reg.cfg.coef1), $past(st_reg.cfg.coef2)})
    else $error("coefficient readback wrong");

  shp_read_a: assert property ( // R09
    rd_addr == `REG_SHP_EN |=>
    rd_data == {7'h00, $past(st_reg.cfg.shp_en)})
    else $error("shaping enable readback wrong");

  unity_path_a: assert property ( // R03 R08
    idle_path_s ##1 eff.pat == PAT_NORMAL |=>
    sample_out == $past(adc_in, 2))
    else $error("unity path altered the sample");

  common_pat_a: assert property ( // R16
    common_ctrl && cha_cfg.pat == PAT_ZEROS |=>
    sample_out == '0)
    else $error("common pattern not applied");

  own_ones_a: assert property ( // R02 R10
    own_ctrl_s(PAT_ONES) |=>
    sample_out == `CODE_MAX)
    else $error("own ones pattern not applied");

  own_zero_a: assert property ( // R10
    own_ctrl_s(PAT_ZEROS) |=>
    sample_out == '0)
    else $error("own zero pattern not applied");

  custom_out_a: assert property ( // R13 R17
    own_ctrl_s(PAT_CUSTOM) |=>
    sample_out == {$past(st_reg.cust_hi), $past(st_reg.cust_lo)})
    else $error("custom word not assembled");

  loop_start_a: assert property ( // R01 R14
    loop_start_s |->
    est == '0 ##1 st_reg.acc == ACC_W'($past(err)))
    else $error("loop did not start from zero");

  loop_fall_a: assert property ( // R14
    eff.corr_en && err < 0 |=>
    st_reg.acc < $past(st_reg.acc))
    else $error("loop not pulling down");

  loop_rise_a: assert property ( // R14
    eff.corr_en && err > 0 |=>
    st_reg.acc > $past(st_reg.acc))
    else $error("loop not pulling up");

  tc_base_a: assert property ( // R04
    st_reg.acc[ACC_W-1:`TC_BASE_SHIFT] == '0 |->
    est == '0)
    else $error("loop faster than shortest constant");

endmodule // chb_digital_cfg
`default_nettype wire

// ### chb_far_side.sv
// converter source and capture receiver facing the channel b block
`default_nettype none
module chb_far_side (
  input  wire logic [10:0] level,
  input  wire logic        mclk,
  input  wire logic [10:0] sample_out,
  output var  logic [10:0] adc_in,
  output var  logic [10:0] captured
);
  timeunit 1ns;
  timeprecision 1ns;
  initial adc_in = 11'h400;
  initial captured = 11'h000;
  // source launches each sample just after the edge
  always @(posedge mclk) adc_in <= #2 level;
  // receiver latches every output word
  always @(posedge mclk) captured <= sample_out;
endmodule // chb_far_side
`default_nettype wire

// ### chb_digital_cfg_tb.sv
// self-checking bench for the channel b config block
`include "chb_consts.svh"
`default_nettype none
module chb_digital_cfg_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import chb_pkg::*;
  logic              mclk = 1'b0;
  logic              rst = 1'b1;
  reg_wr_t           reg_wr = '0;
  logic [7:0]        rd_addr = 8'h00;
  logic [7:0]        rd_data;
  logic              common_ctrl = 1'b0;
  chan_cfg_t         cha_cfg = '0;
  logic [10:0]       level = 11'h400;
  logic [10:0]       adc_in;
  logic [10:0]       sample_out;
  logic [10:0]       captured;
  logic [10:0]       prev;
  shaping_t          shaping;
  int                fails = 0;
  int                tests_run = 0;
  int                cycles = 0;
  chb_digital_cfg i_chb_digital_cfg (.mclk(mclk), .rst(rst), .reg_wr(reg_wr), .rd_addr(rd_addr),
    .rd_data(rd_data), .common_ctrl(common_ctrl), .cha_cfg(cha_cfg), .adc_in(adc_in),
    .sample_out(sample_out), .shaping(shaping));
  chb_far_side i_chb_far_side (.level(level), .mclk(mclk), .sample_out(sample_out), .adc_in(adc_in),
    .captured(captured));
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [10:0] seen, input logic [10:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic do_reset();
    @(posedge mclk);
    #2 rst = 1'b1;
    repeat (5) @(posedge mclk);
    #2 rst = 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr = '{we: 1'b1, addr: a, data: d};
    @(posedge mclk);
    #2 reg_wr.we = 1'b0;
    @(posedge mclk);
    #2;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    rd_addr = a;
    @(posedge mclk);
    #2 d = rd_data;
  endtask
  task automatic settle();
    repeat (4) @(posedge mclk);
    #2;
  endtask
  task automatic t_reset();
    logic [7:0] adr [9] = '{8'h51, 8'h52, 8'h66, 8'h68, 8'h69, 8'h6a, 8'h6c, 8'h75, 8'h76};
    logic [7:0] d;
    foreach (adr[i]) begin
      rd(adr[i], d);
      check({3'h0, d}, 11'h000, "reset value");
    end
    check({2'h0, shaping}, 11'h000, "reset shaping");
    $display("reset test done");
  endtask
  task automatic t_regs();
    logic [7:0] adr [10] = '{8'h51, 8'h52, 8'h66, 8'h68, 8'h69, 8'h6a, 8'h6c, 8'h75, 8'h76, 8'h70};
    logic [7:0] val [10] = '{8'hf8, 8'h3f, 8'h40, 8'h35, 8'ha5, 8'h7f, 8'h01, 8'h05, 8'h3f, 8'hff};
    logic [7:0] d;
    foreach (adr[i]) wr(adr[i], val[i]);
    foreach (adr[i]) begin
      rd(adr[i], d);
      check({3'h0, d}, (i == 9) ? 11'h000 : {3'h0, val[i]}, "readback");
    end
    check({2'h0, shaping}, 11'h1a5, "shaping fields");
    $display("register test done");
  endtask
  task automatic t_patterns();
    logic [2:0]  code [5] = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h0};
    logic [10:0] exp [5] = '{11'h000, 11'h7ff, 11'h2bf, 11'h123, 11'h123};
    level = 11'h123;
    wr(`REG_CUST_LO, 8'hf8);
    wr(`REG_CUST_HI, 8'h15);
    foreach (code[i]) begin
      wr(`REG_PATTERN, {5'h00, code[i]});
      settle();
      check(sample_out, exp[i], "pattern word");
    end
    wr(`REG_PATTERN, 8'h03);
    settle();
    check(sample_out ^ captured, 11'h7ff, "toggle flips");
    check((sample_out == 11'h2aa || sample_out == 11'h555), 11'h001, "toggle word");
    wr(`REG_PATTERN, 8'h04);
    settle();
    prev = sample_out;
    repeat (8) @(posedge mclk);
    #2;
    check(sample_out, prev + 11'h001, "ramp step");
    $display("pattern test done");
  endtask
  task automatic t_gain();
    level = 11'h400;
    wr(`REG_GAIN_TC, 8'hc0);
    settle();
    check(sample_out, 11'h400, "mid code fixed");
    level = 11'h44c;
    settle();
    check((sample_out >= 11'd1174 && sample_out <= 11'd1176), 11'h001, "coarse 6 dB");
    wr(`REG_GAIN_TC, 8'h00);
    wr(`REG_TRIM, 8'h7f);
    level = 11'h600;
    settle();
    check((sample_out >= 11'd1543 && sample_out <= 11'd1544), 11'h001, "fine trim");
    $display("gain test done");
  endtask
  task automatic t_common();
    wr(`REG_PATTERN, 8'h01);
    cha_cfg.pat = PAT_ONES;
    cha_cfg.coef1 = 4'h3;
    cha_cfg.coef2 = 4'hc;
    cha_cfg.shp_en = 1'b1;
    common_ctrl = 1'b1;
    settle();
    check(sample_out, 11'h7ff, "common pattern");
    check({2'h0, shaping}, 11'h13c, "common shaping");
    common_ctrl = 1'b0;
    settle();
    check(sample_out, 11'h000, "own pattern");
    check({2'h0, shaping}, 11'h000, "own shaping");
    $display("common test done");
  endtask
  task automatic t_offset();
    level = 11'h4c8;
    wr(`REG_GAIN_TC, 8'h01);
    wr(`REG_CORR_EN, 8'h40);
    repeat (2000) @(posedge mclk);
    #2;
    check(sample_out, 11'h4c8, "loop constant doubled");
    repeat (1000) @(posedge mclk);
    #2;
    check(sample_out, 11'h4c7, "loop pulls toward mid code");
    wr(`REG_CORR_EN, 8'h00);
    settle();
    check(sample_out, 11'h4c8, "loop disabled");
    level = 11'h400;
    wr(`REG_PEDESTAL, 8'h1f);
    wr(`REG_CORR_EN, 8'h40);
    settle();
    check(sample_out, 11'h401, "loop pulls toward pedestal");
    $display("offset test done");
  endtask
  initial begin
    do_reset();
    t_reset();
    t_regs();
    do_reset();
    t_patterns();
    do_reset();
    t_gain();
    do_reset();
    t_common();
    do_reset();
    t_offset();
    complete_run();
  end
endmodule // chb_digital_cfg_tb
`default_nettype wire
